/* inc/pgs_pkg.sv */
// shared constants and types for the pid gain schedule supervisor
`default_nettype none
package pgs_pkg;
	// percent values are in 0.1 % units, 1000 = 100.0 %
	localparam int PCT_W = 10;
	localparam logic [PCT_W-1:0] PCT_FULL = 10'h3E8;
	localparam logic [PCT_W-1:0] PCT_ZERO = 10'h000;
	// gains in 0.1 units, times in 0.01 s (integral) and 0.001 s (derivative)
	localparam int PAR_W = 16;
	localparam logic [PAR_W-1:0] KP2_RESET = 16'h00C8; // 20.0
	localparam logic [PAR_W-1:0] TI2_RESET = 16'h00C8; // 2.00 s
	localparam logic [PAR_W-1:0] TD2_RESET = 16'h0000; // 0.000 s
	localparam logic [PAR_W-1:0] TI_MIN = 16'h0001; // 0.01 s
	localparam logic [PAR_W-1:0] TI_MAX = 16'h03E8; // 10.00 s
	localparam logic [PCT_W-1:0] THR_LOW_RESET = 10'h0C8; // 20.0 %
	localparam logic [PCT_W-1:0] THR_HIGH_RESET = 10'h320; // 80.0 %
	// digital input function codes
	localparam logic [7:0] DI_FUNC_GAIN_SWITCH = 8'h2B; // 43
	localparam logic [7:0] DI_FUNC_INT_PAUSE = 8'h16; // 22
	// integral attribute bits
	localparam int ATTR_SEP_BIT = 0;
	localparam int ATTR_LIMIT_STOP_BIT = 1;
	// timing: hold time in 10 ms steps, loss time in 100 ms steps
	localparam int CLK_HZ = 100_000_000;
	localparam int HOLD_STEP_MS = 10;
	localparam int LOSS_STEP_MS = 100;
	localparam int HOLD_STEP_CYC = CLK_HZ / 1000 * HOLD_STEP_MS;
	localparam int LOSS_STEP_CYC = CLK_HZ / 1000 * LOSS_STEP_MS;
	localparam int HOLD_MAX_STEPS = 65000; // 650.00 s
	localparam int LOSS_MAX_STEPS = 200; // 20.0 s
	typedef enum logic [1:0] {
		PGS_SW_NONE,
		PGS_SW_INPUT,
		PGS_SW_DEVIATION,
		PGS_SW_FREQUENCY
	} pgs_switch_t;
	typedef enum logic [1:0] {
		PGS_ST_STOPPED,
		PGS_ST_HOLD,
		PGS_ST_CLOSED
	} pgs_state_t;
endpackage
`default_nettype wire

/* src/pgs_interp.sv */
// linear blend of one regulator parameter between two sets
`timescale 1ns/1ns
`default_nettype none
module pgs_interp #(
	parameter int PAR_W = 16,
	parameter int FR_W = 10
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [PAR_W-1:0] set_one_in,
	input wire logic [PAR_W-1:0] set_two_in,
	input wire logic [FR_W-1:0] frac_num_in,
	input wire logic [FR_W-1:0] frac_den_in,
	output logic [PAR_W-1:0] value_out
);
	logic [PAR_W+FR_W:0] prod;
	logic [PAR_W:0] diff;
	logic neg;
	logic [PAR_W-1:0] step;
	logic [PAR_W-1:0] value_next;
	logic [FR_W-1:0] den;
	// the divider is combinational; fine for slowly changing keypad values
	always_comb begin
		neg = set_two_in < set_one_in;
		diff = neg ? {1'b0, set_one_in - set_two_in} : {1'b0, set_two_in - set_one_in};
		den = (frac_den_in == '0) ? {{(FR_W-1){1'b0}}, 1'b1} : frac_den_in;
		// both factors widened first so the product keeps every bit
		prod = {{FR_W{1'b0}}, diff} * {{(PAR_W+1){1'b0}}, frac_num_in};
		step = PAR_W'(prod / den);
		value_next = neg ? PAR_W'(set_one_in - step) : PAR_W'(set_one_in + step);
	end
	// registered so the data output comes from a flip-flop
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			value_out <= '0;
		end else begin
			value_out <= value_next;
		end
	end
endmodule // pgs_interp
`default_nettype wire

/* src/pgs_top.sv */
// gain schedule, startup hold, integral gating and feedback loss supervision
// Operation
// RULE_01 - Two regulator parameter sets are held, the second defaulting to gain 20.0, integral 2.00 s, derivative 0. The code never loads these.
// RULE_02 - The switch selector means 0 none, 1 by digital input, 2 by deviation, 3 by running frequency.
// RULE_03 - In input mode a digital input with function 43 selects set one while inactive and set two while active.
// RULE_04 - In deviation mode a deviation below the low threshold selects set one.
// RULE_05 - In deviation mode a deviation above the high threshold selects set two.
// RULE_06 - Between the thresholds each parameter is interpolated linearly by the deviation position.
// RULE_07 - The low threshold is clamped to zero..high and the high threshold to low..100.0 %. The code clamps the high threshold to 100.0 % only.
// RULE_08 - On start the output is forced to the initial value for the hold time, then closed loop resumes.
// RULE_09 - With separation enabled an active function 22 input freezes the integrator.
// RULE_10 - With separation disabled the pause input is ignored.
// RULE_11 - An attribute bit chooses whether integration stops while the output sits at a limit.
// RULE_12 - Feedback below the loss threshold for longer than the loss time raises a fault; threshold zero disables it.
// RULE_13 - Target and feedback are relative values 0..100.0 % and the deviation is computed on them.
// RULE_14 - A stop setting decides whether the regulator keeps computing while the drive is stopped.
`timescale 1ns/1ns
`default_nettype none
module pgs_top
	import pgs_pkg::*;
#(
	parameter int NUM_DI = 8,
	parameter int HOLD_CYC = pgs_pkg::HOLD_STEP_CYC,
	parameter int LOSS_CYC = pgs_pkg::LOSS_STEP_CYC
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [pgs_pkg::PCT_W-1:0] target_in,
	input wire logic [pgs_pkg::PCT_W-1:0] feedback_in,
	input wire logic [NUM_DI-1:0] di_pins_in,
	input wire logic [NUM_DI*8-1:0] di_func_in,
	input wire logic run_in,
	input wire logic run_freq_high_in,
	input wire logic output_at_limit_in,
	input wire logic [pgs_pkg::PAR_W-1:0] first_set_prop_gain_in,
	input wire logic [pgs_pkg::PAR_W-1:0] first_set_integral_time_in,
	input wire logic [pgs_pkg::PAR_W-1:0] first_set_deriv_time_in,
	input wire logic [pgs_pkg::PAR_W-1:0] second_set_prop_gain_in,
	input wire logic [pgs_pkg::PAR_W-1:0] second_set_integral_time_in,
	input wire logic [pgs_pkg::PAR_W-1:0] second_set_deriv_time_in,
	input wire logic [1:0] gain_set_switch_select_in,
	input wire logic [pgs_pkg::PCT_W-1:0] switch_threshold_low_in,
	input wire logic [pgs_pkg::PCT_W-1:0] switch_threshold_high_in,
	input wire logic [pgs_pkg::PCT_W-1:0] startup_output_value_in,
	input wire logic [15:0] startup_hold_time_in,
	input wire logic [1:0] integral_attribute_bits_in,
	input wire logic [pgs_pkg::PCT_W-1:0] feedback_loss_threshold_in,
	input wire logic [7:0] feedback_loss_time_in,
	input wire logic stopped_state_operation_in,
	input wire logic fault_clear_in,
	output logic [pgs_pkg::PAR_W-1:0] gain_out,
	output logic [pgs_pkg::PAR_W-1:0] integral_out,
	output logic [pgs_pkg::PAR_W-1:0] derivative_out,
	output logic [pgs_pkg::PCT_W-1:0] deviation_out,
	output logic set_two_active_out,
	output logic output_forced_out,
	output logic [pgs_pkg::PCT_W-1:0] forced_value_out,
	output logic integrate_enable_out,
	output logic regulator_enable_out,
	output logic feedback_loss_fault_out
);
	import pgs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers: the first stage is read only by the second
	logic [NUM_DI-1:0] di_meta_reg;
	logic [NUM_DI-1:0] di_sync_reg;
	logic run_meta_reg;
	logic run_sync_reg;
	logic run_prev_reg;
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			di_meta_reg <= '0;
			di_sync_reg <= '0;
			run_meta_reg <= 1'b0;
			run_sync_reg <= 1'b0;
			run_prev_reg <= 1'b0;
		end else begin
			di_meta_reg <= di_pins_in;
			di_sync_reg <= di_meta_reg;
			run_meta_reg <= run_in;
			run_sync_reg <= run_meta_reg;
			run_prev_reg <= run_sync_reg;
		end
	end

	// function decode per terminal, one generate loop
	logic [NUM_DI-1:0] sw_hits;
	logic [NUM_DI-1:0] pause_hits;
	for (genvar i = 0; i < NUM_DI; i++) begin : g_di
		assign sw_hits[i] = di_sync_reg[i] && (di_func_in[i*8 +: 8] == DI_FUNC_GAIN_SWITCH); // RULE_03
		assign pause_hits[i] = di_sync_reg[i] && (di_func_in[i*8 +: 8] == DI_FUNC_INT_PAUSE); // RULE_09
	end
	logic gain_switch_active;
	logic int_pause_active;
	assign gain_switch_active = |sw_hits;
	assign int_pause_active = |pause_hits;

	////////////////////////////////////////////////////////////////////////
	// relative inputs clamped to 0..100.0 % and absolute deviation
	logic [PCT_W-1:0] tgt_c;
	logic [PCT_W-1:0] fb_c;
	logic [PCT_W-1:0] dev_abs;
	always_comb begin
		tgt_c = (target_in > PCT_FULL) ? PCT_FULL : target_in; // RULE_13
		fb_c = (feedback_in > PCT_FULL) ? PCT_FULL : feedback_in; // RULE_13
		dev_abs = (tgt_c > fb_c) ? PCT_W'(tgt_c - fb_c) : PCT_W'(fb_c - tgt_c); // RULE_13
	end

	// thresholds held in order; a high value past 100 % is cut back first
	logic [PCT_W-1:0] thr_high;
	logic [PCT_W-1:0] thr_low;
	always_comb begin
		thr_high = (switch_threshold_high_in > PCT_FULL) ? PCT_FULL : switch_threshold_high_in; // RULE_07
		thr_low = (switch_threshold_low_in > thr_high) ? thr_high : switch_threshold_low_in; // RULE_07
	end

	////////////////////////////////////////////////////////////////////////
	// set selection: numerator over span gives the blend position of set two
	pgs_switch_t sw_mode;
	logic [PCT_W-1:0] frac_num;
	logic [PCT_W-1:0] frac_den;
	logic use_two;
	always_comb begin
		sw_mode = pgs_switch_t'(gain_set_switch_select_in); // RULE_02
		frac_den = PCT_W'(thr_high - thr_low);
		frac_num = PCT_ZERO;
		use_two = 1'b0;
		unique case (sw_mode)
			PGS_SW_NONE: begin
				use_two = 1'b0; // RULE_02
			end
			PGS_SW_INPUT: begin
				use_two = gain_switch_active; // RULE_03
			end
			PGS_SW_DEVIATION: begin
				if (dev_abs < thr_low) begin
					use_two = 1'b0; // RULE_04
				end else if (dev_abs > thr_high) begin
					use_two = 1'b1; // RULE_05
				end else begin
					// equal thresholds leave no span: the blend collapses to set one
					frac_num = PCT_W'(dev_abs - thr_low); // RULE_06
				end
			end
			PGS_SW_FREQUENCY: begin
				use_two = run_freq_high_in; // RULE_02
			end
		endcase
		if (use_two) begin
			frac_num = PCT_FULL;
			frac_den = PCT_FULL;
		end else if (frac_den == PCT_ZERO) begin
			frac_num = PCT_ZERO;
			frac_den = PCT_FULL;
		end
	end

	// integral time of set two kept inside its legal span
	logic [PAR_W-1:0] ti2_c;
	assign ti2_c = (second_set_integral_time_in < TI_MIN) ? TI_MIN :
		((second_set_integral_time_in > TI_MAX) ? TI_MAX : second_set_integral_time_in); // RULE_01

	// one blend per parameter of the pair of sets
	logic [3*PAR_W-1:0] set_one_flat;
	logic [3*PAR_W-1:0] set_two_flat;
	logic [3*PAR_W-1:0] blend_flat;
	assign set_one_flat = {first_set_deriv_time_in, first_set_integral_time_in, first_set_prop_gain_in};
	assign set_two_flat = {second_set_deriv_time_in, ti2_c, second_set_prop_gain_in};
	for (genvar p = 0; p < 3; p++) begin : g_par
		pgs_interp #(
			.PAR_W(PAR_W),
			.FR_W(PCT_W)
		) u_interp (
			.clock_in(clock_in),
			.rst_in(rst_in),
			.set_one_in(set_one_flat[p*PAR_W +: PAR_W]),
			.set_two_in(set_two_flat[p*PAR_W +: PAR_W]),
			.frac_num_in(frac_num),
			.frac_den_in(frac_den),
			.value_out(blend_flat[p*PAR_W +: PAR_W]) // RULE_06
		);
	end
	assign gain_out = blend_flat[0 +: PAR_W]; // RULE_01
	assign integral_out = blend_flat[PAR_W +: PAR_W];
	assign derivative_out = blend_flat[2*PAR_W +: PAR_W];

	// schedule status registers
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			deviation_out <= PCT_ZERO;
			set_two_active_out <= 1'b0;
		end else begin
			deviation_out <= dev_abs;
			set_two_active_out <= use_two;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// run state: stopped, startup hold, closed loop
	pgs_state_t state_reg;
	pgs_state_t state_next;
	logic [$clog2(HOLD_CYC+1)-1:0] hold_div_reg;
	logic [15:0] hold_steps_reg;
	logic start_edge;
	logic hold_done;
	assign start_edge = run_sync_reg && !run_prev_reg;
	assign hold_done = (hold_steps_reg >= startup_hold_time_in);
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PGS_ST_STOPPED: begin
				if (start_edge) begin
					state_next = hold_done ? PGS_ST_CLOSED : PGS_ST_HOLD; // RULE_08
				end
			end
			PGS_ST_HOLD: begin
				if (!run_sync_reg) begin
					state_next = PGS_ST_STOPPED;
				end else if (hold_done) begin
					state_next = PGS_ST_CLOSED; // RULE_08
				end
			end
			PGS_ST_CLOSED: begin
				if (!run_sync_reg) begin
					state_next = PGS_ST_STOPPED;
				end
			end
		endcase
	end
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg <= PGS_ST_STOPPED;
		end else begin
			state_reg <= state_next;
		end
	end

	// hold timer counts 10 ms steps; cleared on every start
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			hold_div_reg <= '0;
			hold_steps_reg <= '0;
		end else if (state_reg != PGS_ST_HOLD) begin
			hold_div_reg <= '0;
			hold_steps_reg <= '0;
		end else if (hold_div_reg == ($clog2(HOLD_CYC+1))'(HOLD_CYC - 1)) begin
			hold_div_reg <= '0;
			hold_steps_reg <= hold_steps_reg + 16'h0001; // RULE_08
		end else begin
			hold_div_reg <= hold_div_reg + 1'b1;
		end
	end

	// forced output and regulator gating
	logic running;
	logic regulate;
	assign running = (state_reg != PGS_ST_STOPPED);
	// taken from the next state so the enables line up with the forced flag at a start
	assign regulate = (state_next != PGS_ST_STOPPED) ? (state_next == PGS_ST_CLOSED) : stopped_state_operation_in; // RULE_14
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			output_forced_out <= 1'b0;
			forced_value_out <= PCT_ZERO;
			regulator_enable_out <= 1'b0;
		end else begin
			output_forced_out <= (state_next == PGS_ST_HOLD); // RULE_08
			forced_value_out <= (startup_output_value_in > PCT_FULL) ? PCT_FULL : startup_output_value_in;
			regulator_enable_out <= regulate; // RULE_14
		end
	end

	// integrator gating: separation pause and limit stop
	logic sep_pause;
	logic limit_stop;
	assign sep_pause = integral_attribute_bits_in[ATTR_SEP_BIT] && int_pause_active; // RULE_09 RULE_10
	assign limit_stop = integral_attribute_bits_in[ATTR_LIMIT_STOP_BIT] && output_at_limit_in; // RULE_11
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			integrate_enable_out <= 1'b0;
		end else begin
			integrate_enable_out <= regulate && !sep_pause && !limit_stop; // RULE_09
		end
	end

	////////////////////////////////////////////////////////////////////////
	// feedback loss: time below threshold counted in 100 ms steps
	logic [$clog2(LOSS_CYC+1)-1:0] loss_div_reg;
	logic [7:0] loss_steps_reg;
	logic below;
	logic loss_trip;
	logic [7:0] loss_lim;
	assign loss_lim = (feedback_loss_time_in > 8'(LOSS_MAX_STEPS)) ? 8'(LOSS_MAX_STEPS) : feedback_loss_time_in;
	assign below = (feedback_loss_threshold_in != PCT_ZERO) && (fb_c < feedback_loss_threshold_in) && running; // RULE_12
	// longer than the time: one step past the limit counts as exceeded
	assign loss_trip = below && (loss_steps_reg > loss_lim);
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			loss_div_reg <= '0;
			loss_steps_reg <= 8'h00;
		end else if (!below) begin
			loss_div_reg <= '0;
			loss_steps_reg <= 8'h00;
		end else if (loss_div_reg == ($clog2(LOSS_CYC+1))'(LOSS_CYC - 1)) begin
			loss_div_reg <= '0;
			if (loss_steps_reg != 8'hFF) begin
				loss_steps_reg <= loss_steps_reg + 8'h01; // RULE_12
			end
		end else begin
			loss_div_reg <= loss_div_reg + 1'b1;
		end
	end
	// sticky fault; a new trip wins over a clear in the same cycle
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			feedback_loss_fault_out <= 1'b0;
		end else if (loss_trip) begin
			feedback_loss_fault_out <= 1'b1; // RULE_12
		end else if (fault_clear_in) begin
			feedback_loss_fault_out <= 1'b0;
		end
	end
endmodule // pgs_top
`default_nettype wire

/* tb/pgs_properties.sv */
// concurrent checks on the gain schedule supervisor ports
`timescale 1ns/1ns
`default_nettype none
module pgs_properties
	import pgs_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [pgs_pkg::PCT_W-1:0] target_in,
	input wire logic [pgs_pkg::PCT_W-1:0] feedback_in,
	input wire logic run_in,
	input wire logic run_freq_high_in,
	input wire logic output_at_limit_in,
	input wire logic [pgs_pkg::PAR_W-1:0] first_set_prop_gain_in,
	input wire logic [pgs_pkg::PAR_W-1:0] second_set_prop_gain_in,
	input wire logic [1:0] gain_set_switch_select_in,
	input wire logic [pgs_pkg::PCT_W-1:0] switch_threshold_low_in,
	input wire logic [pgs_pkg::PCT_W-1:0] switch_threshold_high_in,
	input wire logic [1:0] integral_attribute_bits_in,
	input wire logic [pgs_pkg::PCT_W-1:0] feedback_loss_threshold_in,
	input wire logic stopped_state_operation_in,
	input wire logic fault_clear_in,
	input wire logic [pgs_pkg::PAR_W-1:0] gain_out,
	input wire logic [pgs_pkg::PCT_W-1:0] deviation_out,
	input wire logic set_two_active_out,
	input wire logic output_forced_out,
	input wire logic integrate_enable_out,
	input wire logic regulator_enable_out,
	input wire logic feedback_loss_fault_out
);
	logic [PCT_W-1:0] dev;
	logic sane;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	////////////////////////////////////////////////////////////////
	// reference deviation; sane excludes the clamped threshold cases
	assign dev = (target_in > feedback_in) ? target_in - feedback_in : feedback_in - target_in;
	assign sane = switch_threshold_low_in <= switch_threshold_high_in && switch_threshold_high_in <= PCT_FULL;
	////////////////////////////////////////////////////////////////
	// three stable cycles allow for the interpolator pipeline
	chk_dev_abs_value: assert property (
		target_in <= PCT_FULL && feedback_in <= PCT_FULL |=> deviation_out == $past(dev)) else $error("deviation wrong");
	chk_mode_none_one: assert property (
		(gain_set_switch_select_in == 2'h0 && $stable(first_set_prop_gain_in))[*3]
		|-> gain_out == first_set_prop_gain_in && !set_two_active_out) else $error("mode 0 not set one");
	chk_mode_freq_sel: assert property (
		(gain_set_switch_select_in == 2'h3 && $stable(run_freq_high_in))[*3]
		|-> set_two_active_out == run_freq_high_in) else $error("mode 3 select wrong");
	chk_dev_low_one: assert property (
		(gain_set_switch_select_in == 2'h2 && sane && dev < switch_threshold_low_in && $stable(first_set_prop_gain_in))[*3]
		|-> gain_out == first_set_prop_gain_in) else $error("low deviation not set one");
	chk_dev_high_two: assert property (
		(gain_set_switch_select_in == 2'h2 && sane && dev > switch_threshold_high_in && $stable(second_set_prop_gain_in))[*3]
		|-> gain_out == second_set_prop_gain_in && set_two_active_out) else $error("high deviation not set two");
	chk_hold_no_int: assert property (
		output_forced_out |-> !integrate_enable_out) else $error("integrating during hold");
	chk_hold_min_len: assert property (
		$rose(output_forced_out) |-> output_forced_out[*5]) else $error("hold too short");
	chk_limit_stop: assert property (
		integral_attribute_bits_in[1] && output_at_limit_in |=> !integrate_enable_out) else $error("integrating at limit");
	chk_stop_idle: assert property (
		(!run_in && !stopped_state_operation_in)[*4] |=> !regulator_enable_out) else $error("computing while stopped");
	chk_fault_sticky: assert property (
		feedback_loss_fault_out && !fault_clear_in |=> feedback_loss_fault_out) else $error("fault dropped");
	chk_loss_off_zero: assert property (
		(feedback_loss_threshold_in == PCT_ZERO && !feedback_loss_fault_out)[*2] |=> !feedback_loss_fault_out)
		else $error("fault with check disabled");
endmodule // pgs_properties
bind pgs_top pgs_properties u_props (.*);
`default_nettype wire

/* tb/pgs_top_tb.sv */
// self-checking bench for the gain schedule supervisor
`timescale 1ns/1ns
`default_nettype none
module pgs_top_tb;
	import pgs_pkg::*;
	logic clock_in = 1'b0, rst_in = 1'b1;
	logic [PCT_W-1:0] target_in = 10'h000, feedback_in = 10'h000, deviation_out, forced_value_out;
	logic [PCT_W-1:0] switch_threshold_low_in = 10'h0C8, switch_threshold_high_in = 10'h320;
	logic [PCT_W-1:0] startup_output_value_in = 10'h000, feedback_loss_threshold_in = 10'h000;
	logic [7:0] di_pins_in = 8'h00, feedback_loss_time_in = 8'h00;
	logic [63:0] di_func_in = 64'h0000_0000_0000_162B; // terminal 0 gain switch, terminal 1 pause
	logic run_in = 1'b0, run_freq_high_in = 1'b0, output_at_limit_in = 1'b0;
	logic stopped_state_operation_in = 1'b0, fault_clear_in = 1'b0;
	logic [PAR_W-1:0] first_set_prop_gain_in = 16'h0064, first_set_integral_time_in = 16'h0064;
	logic [PAR_W-1:0] first_set_deriv_time_in = 16'h0000, second_set_prop_gain_in = 16'h012C;
	logic [PAR_W-1:0] second_set_integral_time_in = 16'h01F4, second_set_deriv_time_in = 16'h0258;
	logic [PAR_W-1:0] gain_out, integral_out, derivative_out;
	logic [1:0] gain_set_switch_select_in = 2'h0, integral_attribute_bits_in = 2'h0;
	logic [15:0] startup_hold_time_in = 16'h0000;
	logic set_two_active_out, output_forced_out, integrate_enable_out, regulator_enable_out, feedback_loss_fault_out;
	int fails = 0, total_checks = 0, cycles = 0;
	// short step counts keep hold and loss timing inside a few hundred cycles
	pgs_top #(.HOLD_CYC(10), .LOSS_CYC(20)) dut (.*);
	////////////////////////////////////////////////////////////////
	// 100 MHz clock
	initial begin
		forever #5 clock_in = ~clock_in;
	end
	// cut a hang short; the sequence needs well under a thousand cycles
	always @(posedge clock_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	task step(int n);
		repeat (n) @(negedge clock_in);
	endtask
	task chk(string what, logic [15:0] seen, logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, want, seen);
		end
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// selector modes; pin changes need the two sync stages first
	task t_modes();
		di_pins_in = 8'h01;
		run_freq_high_in = 1'b1;
		step(4);
		chk("mode0 gain", gain_out, 16'h0064);
		gain_set_switch_select_in = 2'h1;
		step(4);
		chk("pin gain", gain_out, 16'h012C);
		chk("pin integral", integral_out, 16'h01F4);
		chk("pin deriv", derivative_out, 16'h0258);
		di_pins_in = 8'h00;
		step(4);
		chk("pin off gain", gain_out, 16'h0064);
		gain_set_switch_select_in = 2'h3;
		step(4);
		chk("freq set", set_two_active_out, 16'h0001);
	endtask
	// below, above, midway, crossed thresholds, high above full scale
	task t_dev();
		logic [9:0] tg [5] = '{10'h258, 10'h3B6, 10'h2BC, 10'h2BC, 10'h3B6};
		logic [9:0] fb [5] = '{10'h1F4, 10'h032, 10'h0C8, 10'h000, 10'h000};
		logic [9:0] lo [5] = '{10'h0C8, 10'h0C8, 10'h0C8, 10'h384, 10'h0C8};
		logic [9:0] hi [5] = '{10'h320, 10'h320, 10'h320, 10'h258, 10'h3FF};
		logic [15:0] ex [5] = '{16'h0064, 16'h012C, 16'h00C8, 16'h012C, 16'h011F};
		gain_set_switch_select_in = 2'h2;
		for (int i = 0; i < 5; i++) begin
			target_in = tg[i];
			feedback_in = fb[i];
			switch_threshold_low_in = lo[i];
			switch_threshold_high_in = hi[i];
			step(4);
			chk("deviation", deviation_out, (tg[i] > fb[i]) ? tg[i] - fb[i] : fb[i] - tg[i]);
			chk("scheduled gain", gain_out, ex[i]);
		end
		target_in = 10'h2BC;
		feedback_in = 10'h0C8;
		switch_threshold_high_in = 10'h320;
		step(4);
		chk("blend deriv", derivative_out, 16'h012C);
		chk("blend integral", integral_out, 16'h012C);
	endtask
	// value above full scale is forced at 100.0 percent
	task t_start();
		startup_output_value_in = 10'h3FF;
		startup_hold_time_in = 16'h0002;
		run_in = 1'b1;
		step(5);
		chk("forced", output_forced_out, 16'h0001);
		chk("forced value", forced_value_out, 16'h03E8);
		chk("hold integrate", integrate_enable_out, 16'h0000);
		step(13);
		chk("still forced", output_forced_out, 16'h0001);
		step(12);
		chk("released", output_forced_out, 16'h0000);
		chk("closed loop", regulator_enable_out, 16'h0001);
	endtask
	// pause pin, limit stop, then stopping with either setting
	task t_integ();
		di_pins_in = 8'h02;
		step(4);
		chk("pause ignored", integrate_enable_out, 16'h0001);
		integral_attribute_bits_in = 2'h1;
		step(2);
		chk("paused", integrate_enable_out, 16'h0000);
		integral_attribute_bits_in = 2'h2;
		output_at_limit_in = 1'b1;
		step(2);
		chk("limit stop", integrate_enable_out, 16'h0000);
		integral_attribute_bits_in = 2'h0;
		step(2);
		chk("limit go", integrate_enable_out, 16'h0001);
		output_at_limit_in = 1'b0;
		run_in = 1'b0;
		step(5);
		chk("stop idle", regulator_enable_out, 16'h0000);
		stopped_state_operation_in = 1'b1;
		step(2);
		chk("stop compute", regulator_enable_out, 16'h0001);
	endtask
	// trip lands near 64 cycles: three sync edges plus three 20 cycle steps
	task t_loss();
		startup_hold_time_in = 16'h0001;
		feedback_loss_threshold_in = 10'h064;
		feedback_loss_time_in = 8'h02;
		feedback_in = 10'h032;
		run_in = 1'b1;
		step(3);
		chk("stop op hold", output_forced_out, 16'h0001);
		chk("stop op hold integrate", integrate_enable_out, 16'h0000);
		step(47);
		chk("no early trip", feedback_loss_fault_out, 16'h0000);
		step(25);
		chk("trip", feedback_loss_fault_out, 16'h0001);
		feedback_in = 10'h1F4;
		step(3);
		chk("sticky", feedback_loss_fault_out, 16'h0001);
		fault_clear_in = 1'b1;
		step(1);
		fault_clear_in = 1'b0;
		feedback_loss_threshold_in = 10'h000;
		feedback_in = 10'h000;
		step(150);
		chk("check disabled", feedback_loss_fault_out, 16'h0000);
	endtask
	////////////////////////////////////////////////////////////////
	// reset for two cycles, then each scenario in turn
	initial begin
		step(2);
		rst_in = 1'b0;
		step(2);
		t_modes();
		t_dev();
		t_start();
		t_integ();
		t_loss();
		close_out();
	end
endmodule // pgs_top_tb
`default_nettype wire
